/* design/spi_shift_engine.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_shift_engine #(parameter int unsigned DIV_W = 12) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  shift_if.eng sh
);
  usart_spi_pkg::eng_state_t state_q;
  logic [DIV_W-1:0] div_q;
  logic [3:0] edge_q;
  logic sck_q;
  logic done_q;
  logic [7:0] tx_sr_q;
  logic [7:0] rx_sr_q;
  logic tick;
  logic sample_now;
  logic shift_now;

  // Half-period tick from the divisor, counting only while running
  assign tick = (state_q == usart_spi_pkg::ENG_RUN) && (div_q == sh.divisor);
  // Even edge index is the leading edge of a clock period
  assign sample_now = edge_q[0] ^ ~sh.cpha;
  // Phase one skips the first shift: that bit is already on the line
  assign shift_now = !sample_now && !(sh.cpha && edge_q == 4'h0);

  // Divisor counter
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
    end else if (ce_i) begin
      if (tick || state_q == usart_spi_pkg::ENG_IDLE) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // Frame sequencer: sixteen clock edges make eight bits
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= usart_spi_pkg::ENG_IDLE;
      edge_q <= 4'h0;
      sck_q <= 1'b0;
      done_q <= 1'b0;
      tx_sr_q <= 8'h00;
      rx_sr_q <= 8'h00;
    end else if (ce_i) begin
      done_q <= 1'b0;
      case (state_q)
        usart_spi_pkg::ENG_IDLE: begin
          if (sh.start) begin
            tx_sr_q <= sh.tx_byte;
            edge_q <= 4'h0;
            sck_q <= 1'b0;
            state_q <= usart_spi_pkg::ENG_RUN;
          end
        end
        usart_spi_pkg::ENG_RUN: begin
          if (tick) begin
            sck_q <= ~sck_q;
            edge_q <= edge_q + 4'h1;
            if (sample_now && sh.lsb_first) begin
              rx_sr_q <= {sh.miso, rx_sr_q[7:1]};
            end else if (sample_now) begin
              rx_sr_q <= {rx_sr_q[6:0], sh.miso};
            end
            if (shift_now && sh.lsb_first) begin
              tx_sr_q <= {1'b0, tx_sr_q[7:1]};
            end else if (shift_now) begin
              tx_sr_q <= {tx_sr_q[6:0], 1'b0};
            end
            if (edge_q == usart_spi_pkg::EDGE_LAST) begin
              state_q <= usart_spi_pkg::ENG_IDLE;
              done_q <= 1'b1;
            end
          end
        end
        default: state_q <= usart_spi_pkg::ENG_IDLE;
      endcase
    end
  end

  assign sh.busy = (state_q == usart_spi_pkg::ENG_RUN);
  assign sh.done = done_q;
  assign sh.rx_byte = rx_sr_q;
  assign sh.mosi = sh.lsb_first ? tx_sr_q[0] : tx_sr_q[7];
  // Idle level equals polarity since sck_q rests low
  assign sh.sck = sck_q ^ sh.cpol;
endmodule : spi_shift_engine
`default_nettype wire

/* design/sync_2ff.sv */
`timescale 1ns/10ps
`default_nettype none
module sync_2ff (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  // First stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : sync_2ff
`default_nettype wire

/* design/usart_master_spi_control.sv */
`timescale 1ns/10ps
`default_nettype none
module usart_master_spi_control #(parameter int unsigned DIV_W = 12) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic global_irq_en_i,
  input wire logic tx_irq_ack_i,
  input wire logic serial_in_pin_i,
  output logic serial_in_owned_o,
  output logic serial_out_pin_o,
  output logic serial_out_oe_o,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_oe_o,
  output logic rx_irq_o,
  output logic tx_irq_o,
  output logic empty_irq_o
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic ap_valid;
  logic rd_req;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wdat;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_q;
  logic rxcie_q;
  logic txcie_q;
  logic buffer_empty_irq_en_q;
  logic rxen_q;
  logic txen_q;
  usart_spi_pkg::usart_mode_t mode_q;
  logic order_q;
  logic cpha_q;
  logic cpol_q;
  logic [DIV_W-1:0] baud_q;
  logic tx_active_q;
  logic [7:0] txbuf_q;
  logic txbuf_full_q;
  logic txc_q;
  logic [7:0] rx_mem_q [2];
  logic rd_ptr_q;
  logic [1:0] rx_cnt_q;
  logic rx_pop;
  logic rx_push;
  logic rxc;
  logic udre;
  logic start;
  logic miso_sync;
  logic data_wr;
  logic status_wr;

  shift_if #(.DIV_W(DIV_W)) sh ();

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: zero-wait, always OKAY
  assign ap_valid = hsel_i && htrans_i[1] && hready_i;
  assign rd_req = ap_valid && !hwrite_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;
  assign wdat = hwdata_i[7:0];
  assign data_wr = wr_pend_q && (wr_addr_q == usart_spi_pkg::ADDR_DATA);
  assign status_wr = wr_pend_q && (wr_addr_q == usart_spi_pkg::ADDR_STATUS);

  // Write address held into the data phase
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (ce_i) begin
      wr_pend_q <= ap_valid && hwrite_i;
      wr_addr_q <= haddr_i[7:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_i[7:0] == usart_spi_pkg::ADDR_DATA) begin
      rd_mux[7:0] = rx_mem_q[rd_ptr_q];
    end else if (haddr_i[7:0] == usart_spi_pkg::ADDR_STATUS) begin
      // Error flags and reserved bits stay zero
      rd_mux[usart_spi_pkg::RXC_BIT] = rxc;
      rd_mux[usart_spi_pkg::TXC_BIT] = txc_q;
      rd_mux[usart_spi_pkg::UDRE_BIT] = udre;
    end else if (haddr_i[7:0] == usart_spi_pkg::ADDR_CTRL) begin
      rd_mux[usart_spi_pkg::RXCIE_BIT] = rxcie_q;
      rd_mux[usart_spi_pkg::TXCIE_BIT] = txcie_q;
      rd_mux[usart_spi_pkg::BUFFER_EMPTY_IRQ_EN_BIT] = buffer_empty_irq_en_q;
      rd_mux[usart_spi_pkg::RXEN_BIT] = rxen_q;
      rd_mux[usart_spi_pkg::TXEN_BIT] = txen_q;
    end else if (haddr_i[7:0] == usart_spi_pkg::ADDR_MODE) begin
      rd_mux[usart_spi_pkg::MODE_HI:usart_spi_pkg::MODE_LO] = mode_q;
      rd_mux[usart_spi_pkg::ORDER_BIT] = order_q;
      rd_mux[usart_spi_pkg::CPHA_BIT] = cpha_q;
      rd_mux[usart_spi_pkg::CPOL_BIT] = cpol_q;
    end else if (haddr_i[7:0] == usart_spi_pkg::ADDR_BAUD) begin
      rd_mux[DIV_W-1:0] = baud_q;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce_i && rd_req) begin
      hrdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control, mode and baud registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rxcie_q <= usart_spi_pkg::CTRL_RST[usart_spi_pkg::RXCIE_BIT];
      txcie_q <= usart_spi_pkg::CTRL_RST[usart_spi_pkg::TXCIE_BIT];
      buffer_empty_irq_en_q <= usart_spi_pkg::CTRL_RST[usart_spi_pkg::BUFFER_EMPTY_IRQ_EN_BIT];
      rxen_q <= usart_spi_pkg::CTRL_RST[usart_spi_pkg::RXEN_BIT];
      txen_q <= usart_spi_pkg::CTRL_RST[usart_spi_pkg::TXEN_BIT];
    end else if (ce_i && wr_pend_q
        && wr_addr_q == usart_spi_pkg::ADDR_CTRL) begin
      // Low three bits have no storage
      rxcie_q <= wdat[usart_spi_pkg::RXCIE_BIT];
      txcie_q <= wdat[usart_spi_pkg::TXCIE_BIT];
      buffer_empty_irq_en_q <= wdat[usart_spi_pkg::BUFFER_EMPTY_IRQ_EN_BIT];
      rxen_q <= wdat[usart_spi_pkg::RXEN_BIT];
      txen_q <= wdat[usart_spi_pkg::TXEN_BIT];
    end
  end

  // Mode and format land together in one write
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_q <= usart_spi_pkg::usart_mode_t'(
        usart_spi_pkg::MODE_RST[usart_spi_pkg::MODE_HI:
        usart_spi_pkg::MODE_LO]);
      order_q <= usart_spi_pkg::MODE_RST[usart_spi_pkg::ORDER_BIT];
      cpha_q <= usart_spi_pkg::MODE_RST[usart_spi_pkg::CPHA_BIT];
      cpol_q <= usart_spi_pkg::MODE_RST[usart_spi_pkg::CPOL_BIT];
    end else if (ce_i && wr_pend_q
        && wr_addr_q == usart_spi_pkg::ADDR_MODE) begin
      mode_q <= usart_spi_pkg::usart_mode_t'(
        wdat[usart_spi_pkg::MODE_HI:usart_spi_pkg::MODE_LO]);
      order_q <= wdat[usart_spi_pkg::ORDER_BIT];
      cpha_q <= wdat[usart_spi_pkg::CPHA_BIT];
      cpol_q <= wdat[usart_spi_pkg::CPOL_BIT];
    end
  end

  // Baud divisor
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      baud_q <= DIV_W'(usart_spi_pkg::BAUD_RST);
    end else if (ce_i && wr_pend_q
        && wr_addr_q == usart_spi_pkg::ADDR_BAUD) begin
      baud_q <= hwdata_i[DIV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit side
  // Only master SPI mode moves data; other modes are not built here
  assign start = txbuf_full_q && !sh.busy && tx_active_q
    && (mode_q == usart_spi_pkg::MODE_MSPI);
  assign udre = !txbuf_full_q;

  // Transmit buffer: writes while full are dropped
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      txbuf_full_q <= 1'b0;
      txbuf_q <= 8'h00;
    end else if (ce_i) begin
      if (data_wr && !txbuf_full_q && txen_q) begin
        txbuf_full_q <= 1'b1;
        txbuf_q <= wdat;
      end else if (start) begin
        txbuf_full_q <= 1'b0;
      end
    end
  end

  // Disable takes hold only once nothing is left to send
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_active_q <= 1'b0;
    end else if (ce_i) begin
      if (txen_q) begin
        tx_active_q <= 1'b1;
      end else if (!sh.busy && !txbuf_full_q) begin
        tx_active_q <= 1'b0;
      end
    end
  end

  // Complete flag; a frame end with the buffer empty beats a same-cycle clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      txc_q <= 1'b0;
    end else if (ce_i) begin
      if (sh.done && !txbuf_full_q) begin
        txc_q <= 1'b1;
      end else if (tx_irq_ack_i
          || (status_wr && wdat[usart_spi_pkg::TXC_BIT])) begin
        txc_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive side: two-entry buffer
  assign rxc = (rx_cnt_q != 2'h0);
  assign rx_pop = rd_req && (haddr_i[7:0] == usart_spi_pkg::ADDR_DATA)
    && rxc;
  // Full buffer drops the newest byte
  assign rx_push = sh.done && rxen_q
    && (rx_cnt_q != usart_spi_pkg::RX_DEPTH);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rx_cnt_q <= 2'h0;
      rd_ptr_q <= 1'b0;
    end else if (ce_i) begin
      if (!rxen_q) begin
        rx_cnt_q <= 2'h0;
      end else begin
        rx_cnt_q <= rx_cnt_q + {1'b0, rx_push} - {1'b0, rx_pop};
      end
      if (rx_pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  // Storage needs no reset; the count says what is valid
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && rx_push) begin
      rx_mem_q[rd_ptr_q ^ rx_cnt_q[0]] <= sh.rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Engine and pins
  assign sh.start = start;
  assign sh.tx_byte = txbuf_q;
  assign sh.lsb_first = order_q;
  assign sh.cpha = cpha_q;
  assign sh.cpol = cpol_q;
  assign sh.divisor = baud_q;
  assign sh.miso = miso_sync;

  sync_2ff u_miso_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .d_i(serial_in_pin_i),
    .q_o(miso_sync)
  );

  spi_shift_engine #(.DIV_W(DIV_W)) u_engine (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .sh(sh.eng)
  );

  // Pin ownership follows the enables
  assign serial_in_owned_o = rxen_q;
  assign serial_out_oe_o = tx_active_q;
  assign transfer_clock_oe_o = tx_active_q;
  assign serial_out_pin_o = sh.mosi;
  assign transfer_clock_pin_o = sh.sck;

  // Requests gated by enable and the global flag
  assign rx_irq_o = rxcie_q && global_irq_en_i && rxc;
  assign tx_irq_o = txcie_q && global_irq_en_i && txc_q;
  assign empty_irq_o = buffer_empty_irq_en_q && global_irq_en_i && udre;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence frame_end_idle;
    ce_i && sh.done && !txbuf_full_q;
  endsequence
  sequence txc_clear_req;
    ce_i && !sh.done && (tx_irq_ack_i || (status_wr && wdat[6]));
  endsequence

  rxc_level_a: assert property (ce_i && rx_push && !rx_pop |=> rxc)
    else $error("receive flag missed a stored byte");
  txc_set_a: assert property (frame_end_idle |=> txc_q)
    else $error("transmit-complete not set at frame end");
  txc_clear_a: assert property (txc_clear_req |=> !txc_q)
    else $error("transmit-complete not cleared");
  udre_reset_a: assert property ($past(sys_rst_i) |-> udre)
    else $error("buffer-empty low after reset");
  irq_gate_a: assert property (
    (rx_irq_o |-> rxcie_q && global_irq_en_i && rxc) and
    (tx_irq_o |-> txcie_q && global_irq_en_i && txc_q) and
    (empty_irq_o |-> buffer_empty_irq_en_q && global_irq_en_i && udre))
    else $error("interrupt raised without its conditions");
  rx_flush_a: assert property (ce_i && !rxen_q |=> !rxc)
    else $error("receive buffer not flushed");
  tx_defer_a: assert property (
    tx_active_q && (sh.busy || txbuf_full_q) |=> tx_active_q)
    else $error("transmitter released with data pending");
  overflow_keep_a: assert property (
    ce_i && rx_cnt_q == 2'h2 && !rx_pop && rxen_q
    |=> rx_cnt_q == 2'h2 && $stable(rd_ptr_q))
    else $error("overflow disturbed buffered data");
  err_zero_a: assert property (
    $past(ce_i && rd_req) && $past(haddr_i[7:0]) == 8'h04
    |-> hrdata_o[4:0] == 5'h00)
    else $error("error flags read non-zero");
endmodule : usart_master_spi_control
`default_nettype wire

/* shared/shift_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface shift_if #(parameter int unsigned DIV_W = 12);
  logic start;
  logic [7:0] tx_byte;
  logic lsb_first;
  logic cpha;
  logic cpol;
  logic [DIV_W-1:0] divisor;
  logic miso;
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  logic mosi;
  logic sck;
  modport ctl (output start, tx_byte, lsb_first, cpha, cpol, divisor,
    miso, input busy, done, rx_byte, mosi, sck);
  modport eng (input start, tx_byte, lsb_first, cpha, cpol, divisor,
    miso, output busy, done, rx_byte, mosi, sck);
endinterface : shift_if
`default_nettype wire

/* shared/usart_spi_pkg.sv */
package usart_spi_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  // Status field positions
  localparam int unsigned RXC_BIT = 7;
  localparam int unsigned TXC_BIT = 6;
  localparam int unsigned UDRE_BIT = 5;
  // Control field positions
  localparam int unsigned RXCIE_BIT = 7;
  localparam int unsigned TXCIE_BIT = 6;
  localparam int unsigned BUFFER_EMPTY_IRQ_EN_BIT = 5;
  localparam int unsigned RXEN_BIT = 4;
  localparam int unsigned TXEN_BIT = 3;
  // Mode register field positions
  localparam int unsigned MODE_HI = 7;
  localparam int unsigned MODE_LO = 6;
  localparam int unsigned ORDER_BIT = 2;
  localparam int unsigned CPHA_BIT = 1;
  localparam int unsigned CPOL_BIT = 0;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h06;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [11:0] BAUD_RST = 12'h000;
  // Frame shape
  localparam int unsigned FRAME_BITS = 8;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam logic [1:0] RX_DEPTH = 2'h2;
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_SYNC = 2'b01,
    MODE_RSVD = 2'b10,
    MODE_MSPI = 2'b11
  } usart_mode_t;
  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } eng_state_t;
endpackage : usart_spi_pkg

/* sim/spi_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_first_i,
  input wire logic clr_i,
  input wire logic [7:0] reply_base_i,
  output logic miso_o,
  output logic [7:0] got_o,
  output int frames_o
);
  logic [7:0] shreg;
  logic [7:0] reply;
  logic [2:0] pos;
  logic prev;
  int cnt;
  initial begin
    shreg = 8'h00;
    got_o = 8'h00;
    frames_o = 0;
    cnt = 0;
    pos = 3'h0;
    prev = 1'bx;
  end
  // Each frame answers with the next byte of a rising count
  assign reply = reply_base_i + frames_o[7:0];
  assign miso_o = reply[lsb_first_i ? pos : 3'h7 - pos];
  // Resync after a mode change, as idle-level swaps look like edges
  always @(posedge clr_i) begin
    cnt = 0;
    pos = 3'h0;
  end
  // Sample on one edge kind, shift on the other
  always @(sck_i) begin
    if (prev !== 1'bx) begin
      if ((sck_i !== cpol_i) == !cpha_i) begin
        shreg = lsb_first_i ? {mosi_i, shreg[7:1]} : {shreg[6:0], mosi_i};
        cnt++;
        if (cnt == 8) begin
          got_o = shreg;
          cnt = 0;
          frames_o++;
        end
      end else begin
        pos = cnt[2:0];
      end
    end
    prev = sck_i;
  end
endmodule : spi_slave_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys_i, sys_rst_i, hsel, hwrite, glb, ack, hreadyout, hresp;
  logic owned, sout, soe, sck, sck_oe, rx_irq, tx_irq, e_irq, miso;
  logic cpol, cpha, lsb, clr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] got;
  int frames, err_total, checked, cyc, f;
  usart_master_spi_control #(.DIV_W(12)) usart_master_spi_control_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .global_irq_en_i(glb), .tx_irq_ack_i(ack), .serial_in_pin_i(miso),
    .serial_in_owned_o(owned), .serial_out_pin_o(sout),
    .serial_out_oe_o(soe), .transfer_clock_pin_o(sck),
    .transfer_clock_oe_o(sck_oe), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq),
    .empty_irq_o(e_irq));
  spi_slave_model spi_slave_model_i (.sck_i(sck), .mosi_i(sout),
    .cpol_i(cpol), .cpha_i(cpha), .lsb_first_i(lsb), .clr_i(clr),
    .reply_base_i(8'h3C), .miso_o(miso), .got_o(got), .frames_o(frames));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask : chk
  // One AHB single word transfer; address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdchk
  // Poll status until the flag rises, bounded by the hang guard
  task automatic wait_flag(input int unsigned b);
    rd = 32'h0000_0000;
    while (rd[b] !== 1'b1) bus(1'b0, usart_spi_pkg::ADDR_STATUS, 0);
  endtask : wait_flag
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(usart_spi_pkg::ADDR_STATUS, 32'h0000_0020);
    rdchk(usart_spi_pkg::ADDR_CTRL, 32'h0000_0000);
    rdchk(usart_spi_pkg::ADDR_MODE, 32'h0000_0006);
    chk({soe, owned, rx_irq, tx_irq, e_irq}, 5'h00);
    // Zero-wait slave that always answers OKAY
    chk({hreadyout, hresp}, 2'b10);
    wr(usart_spi_pkg::ADDR_MODE, 32'h0000_00FF);
    rdchk(usart_spi_pkg::ADDR_MODE, 32'h0000_00C7);
    $display("reset test done");
  endtask : t_reset
  // Every order, phase and polarity setting in turn
  task automatic t_modes();
    wr(usart_spi_pkg::ADDR_BAUD, 32'h0000_0003);
    wr(usart_spi_pkg::ADDR_CTRL, 32'h0000_0018);
    for (int m = 0; m < 8; m++) begin
      {lsb, cpha, cpol} = m[2:0];
      wr(usart_spi_pkg::ADDR_MODE, 32'h0000_00C0 | m);
      rdchk(usart_spi_pkg::ADDR_MODE, 32'h0000_00C0 | m);
      #1 chk(sck, cpol);
      clr = 1'b1;
      #1 clr = 1'b0;
      f = frames;
      wr(usart_spi_pkg::ADDR_DATA, 32'h0000_005A ^ m);
      wait_flag(usart_spi_pkg::RXC_BIT);
      chk(got, 8'h5A ^ m);
      rdchk(usart_spi_pkg::ADDR_DATA, 8'h3C + f);
      rdchk(usart_spi_pkg::ADDR_STATUS, 32'h0000_0060);
      wr(usart_spi_pkg::ADDR_STATUS, 32'h0000_0040);
      rdchk(usart_spi_pkg::ADDR_STATUS, 32'h0000_0020);
    end
    $display("modes test done");
  endtask : t_modes
  task automatic t_overflow();
    f = frames;
    for (int i = 0; i < 3; i++) begin
      wait_flag(usart_spi_pkg::UDRE_BIT);
      wr(usart_spi_pkg::ADDR_DATA, 32'h0000_0011 + i);
    end
    wait_flag(usart_spi_pkg::TXC_BIT);
    #1 chk(frames, f + 3);
    rdchk(usart_spi_pkg::ADDR_DATA, 8'h3C + f);
    rdchk(usart_spi_pkg::ADDR_DATA, 8'h3D + f);
    rdchk(usart_spi_pkg::ADDR_STATUS, 32'h0000_0060);
    wr(usart_spi_pkg::ADDR_STATUS, 32'h0000_0040);
    $display("overflow test done");
  endtask : t_overflow
  task automatic t_irq();
    wr(usart_spi_pkg::ADDR_CTRL, 32'h0000_00F8);
    #1 chk({rx_irq, tx_irq, e_irq}, 3'h0);
    glb <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk({rx_irq, tx_irq, e_irq}, 3'h1);
    wr(usart_spi_pkg::ADDR_DATA, 32'h0000_0077);
    wait_flag(usart_spi_pkg::TXC_BIT);
    #1 chk({rx_irq, tx_irq, e_irq}, 3'h7);
    @(posedge clk_sys_i);
    ack <= 1'b1;
    @(posedge clk_sys_i);
    ack <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk(tx_irq, 1'b0);
    bus(1'b0, usart_spi_pkg::ADDR_DATA, 0);
    #1 chk(rx_irq, 1'b0);
    glb <= 1'b0;
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_enables();
    wr(usart_spi_pkg::ADDR_DATA, 32'h0000_0001);
    wait_flag(usart_spi_pkg::RXC_BIT);
    wr(usart_spi_pkg::ADDR_CTRL, 32'h0000_0008);
    rdchk(usart_spi_pkg::ADDR_STATUS, 32'h0000_0060);
    chk(owned, 1'b0);
    // Stale complete flag would end the drain wait at once
    wr(usart_spi_pkg::ADDR_STATUS, 32'h0000_0040);
    rdchk(usart_spi_pkg::ADDR_STATUS, 32'h0000_0020);
    f = frames;
    wr(usart_spi_pkg::ADDR_DATA, 32'h0000_0002);
    wait_flag(usart_spi_pkg::UDRE_BIT);
    wr(usart_spi_pkg::ADDR_DATA, 32'h0000_0003);
    wr(usart_spi_pkg::ADDR_CTRL, 32'h0000_0000);
    #1 chk(soe, 1'b1);
    wait_flag(usart_spi_pkg::TXC_BIT);
    repeat (4) @(posedge clk_sys_i);
    #1 chk({soe, sck_oe}, 2'h0);
    chk(frames, f + 2);
    wr(usart_spi_pkg::ADDR_MODE, 32'h0000_0040);
    wr(usart_spi_pkg::ADDR_CTRL, 32'h0000_0018);
    f = frames;
    wr(usart_spi_pkg::ADDR_DATA, 32'h0000_0004);
    repeat (200) @(posedge clk_sys_i);
    chk(frames, f);
    $display("enable test done");
  endtask : t_enables
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst_i, hsel, hwrite, glb, ack, clr} = 6'h21;
    {cpol, cpha, lsb} = 3'h0;
    {haddr, hwdata, htrans} = '0;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    clr = 1'b0;
    t_reset();
    t_modes();
    t_overflow();
    t_irq();
    t_enables();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
